// [hdl/power_state_tracker.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Fully-off device ignores every address decode.
// - Off discards context; reinit needed, longest restore.
// - Fully-on device active, keeps context, no restore.
// - Device power strictly decreases through intermediate states.
// - Internal modes switch only when software-invisible.
// - Visible or slow modes need driver command.
// - Lightest sleep keeps processor and chipset context.
// - Second sleep loses cpu context; wake at reset.
// - Third sleep keeps memory, restores config, reset vector.
// - Lowest sleep: devices off, platform context kept.
// - Soft off coded apart from lowest sleep.
// - Active processor state executes instructions.
// - First idle stops execution, negligible latency.
// - Second idle saves more, reports bounded exit.
// - Deepest idle keeps caches, ignores snoops.
// - Performance states apply only when executing/fully on.
// - Top state maximum; next below maximum.
// - At most sixteen states; last is minimum.
module power_state_tracker
  import power_state_pkg::*;
#(
  parameter int         PERF_STATES = PERF_MAX_STATES,
  parameter logic [1:0] AUTO_MODES  = 2'h3
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Software requests
  input  wire pm_req_t      req,
  // Hardware request for a transparent internal mode
  input  wire logic         auto_mode_req,
  input  wire logic [1:0]   auto_mode,
  // Bus address decode from the device
  input  wire logic         addr_hit,
  // Current states
  output logic              addr_claim,
  output dev_state_t        dev_state,
  output sleep_state_t      sleep_state,
  output cpu_state_t        cpu_state,
  output logic [3:0]        perf_state,
  output logic [1:0]        int_mode,
  output pm_policy_t        policy,
  output logic              req_error
);

  localparam logic [3:0] PERF_LAST = 4'(PERF_STATES - 1);

  initial begin
    if (PERF_STATES > PERF_MAX_STATES || PERF_STATES < 1) begin
      $error("PERF_STATES out of range");
    end
  end

  typedef struct packed {
    dev_state_t   dev;
    sleep_state_t sleep;
    cpu_state_t   cpu;
    logic [3:0]   perf;
    logic [1:0]   mode;
    logic         claim;
    logic         err;
    pm_policy_t   pol;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [1:0] dev_power(input dev_state_t d);
    case (d)
      dev_full_on: dev_power = PWR_LVL_FULL;
      dev_light:   dev_power = PWR_LVL_LIGHT;
      dev_deep:    dev_power = PWR_LVL_DEEP;
      default:     dev_power = PWR_LVL_OFF;
    endcase
  endfunction

  function automatic logic valid_sleep(input sleep_state_t v);
    valid_sleep = (v <= sleep_soft_off);
  endfunction

  function automatic pm_policy_t make_policy(input dev_state_t d, input sleep_state_t sl,
                                             input cpu_state_t c, input logic [3:0] p);
    pm_policy_t r;
    r = '0;
    r.decode_en           = (d != dev_off);
    r.context_kept        = (d == dev_full_on) || (d == dev_light);
    r.need_reinit         = (d == dev_off);
    r.power_level         = dev_power(d);
    r.cpu_ctx_kept        = (sl == sleep_none) || (sl == sleep_s1);
    r.cache_ctx_kept      = (sl == sleep_none) || (sl == sleep_s1);
    r.mem_only_kept       = (sl == sleep_s3);
    r.restore_cfg         = (sl == sleep_s3);
    r.wake_at_reset_vec   = (sl == sleep_s2) || (sl == sleep_s3);
    r.devices_off         = (sl == sleep_s4) || (sl == sleep_soft_off);
    r.longest_wake        = (sl == sleep_s4);
    r.boot_from_image     = (sl == sleep_s4);
    r.cpu_executing       = (c == cpu_active) && (sl == sleep_none);
    r.snoop_ignore        = (c == cpu_idle3);
    r.exit_latency_report = (c == cpu_idle2) || (c == cpu_idle3);
    r.perf_applies        = r.cpu_executing || (d == dev_full_on);
    r.perf_max            = r.perf_applies && (p == PERF_TOP);
    r.perf_min            = r.perf_applies && (p == PERF_LAST);
    return r;
  endfunction

  always_comb begin
    s_d     = s_q;
    s_d.err = 1'b0;
    // Device state; off clears the internal mode unless a mode command comes in the same cycle
    if (req.dev_valid) begin
      s_d.dev = req.dev;
      if (req.dev == dev_off) begin
        s_d.mode = 2'h0;
      end
    end
    if (req.sleep_valid) begin
      if (valid_sleep(req.sleep)) begin
        s_d.sleep = req.sleep;
      end else begin
        s_d.err = 1'b1;
      end
    end
    if (req.cpu_valid) begin
      s_d.cpu = req.cpu;
    end
    if (req.perf_valid) begin
      if (req.perf <= PERF_LAST) begin
        s_d.perf = req.perf;
      end else begin
        s_d.err = 1'b1;
      end
    end
    // Driver command may select any mode, visible or not
    if (req.mode_valid) begin
      s_d.mode = req.mode;
    end else if (auto_mode_req) begin
      if (auto_mode <= AUTO_MODES && s_d.dev != dev_off) begin
        s_d.mode = auto_mode;
      end
    end
    s_d.pol   = make_policy(s_d.dev, s_d.sleep, s_d.cpu, s_d.perf);
    s_d.claim = addr_hit && (s_q.dev != dev_off);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q.dev   <= dev_full_on;
      s_q.sleep <= sleep_none;
      s_q.cpu   <= cpu_active;
      s_q.perf  <= PERF_TOP;
      s_q.mode  <= 2'h0;
      s_q.claim <= 1'b0;
      s_q.err   <= 1'b0;
      s_q.pol   <= make_policy(dev_full_on, sleep_none, cpu_active, PERF_TOP);
    end else begin
      s_q <= s_d;
    end
  end

  assign addr_claim  = s_q.claim;
  assign dev_state   = s_q.dev;
  assign sleep_state = s_q.sleep;
  assign cpu_state   = s_q.cpu;
  assign perf_state  = s_q.perf;
  assign int_mode    = s_q.mode;
  assign policy      = s_q.pol;
  assign req_error   = s_q.err;

endmodule

// [hdl/power_state_pkg.sv]
package power_state_pkg;

  // Device power states, ordered by decreasing power
  typedef enum logic [1:0] {
    dev_full_on = 2'h0,
    dev_light   = 2'h1,
    dev_deep    = 2'h2,
    dev_off     = 2'h3
  } dev_state_t;

  // Sleeping states; soft off has its own code
  typedef enum logic [2:0] {
    sleep_none     = 3'h0,
    sleep_s1       = 3'h1,
    sleep_s2       = 3'h2,
    sleep_s3       = 3'h3,
    sleep_s4       = 3'h4,
    sleep_soft_off = 3'h5
  } sleep_state_t;

  // Processor power states
  typedef enum logic [1:0] {
    cpu_active = 2'h0,
    cpu_idle1  = 2'h1,
    cpu_idle2  = 2'h2,
    cpu_idle3  = 2'h3
  } cpu_state_t;

  localparam int          PERF_MAX_STATES = 16;
  localparam logic [3:0]  PERF_TOP        = 4'h0;
  localparam logic [3:0]  PERF_LAST_DFLT  = 4'hf;

  // Relative power levels, 3 is highest
  localparam logic [1:0]  PWR_LVL_FULL  = 2'h3;
  localparam logic [1:0]  PWR_LVL_LIGHT = 2'h2;
  localparam logic [1:0]  PWR_LVL_DEEP  = 2'h1;
  localparam logic [1:0]  PWR_LVL_OFF   = 2'h0;

  // Software request
  typedef struct packed {
    logic         dev_valid;
    dev_state_t   dev;
    logic         sleep_valid;
    sleep_state_t sleep;
    logic         cpu_valid;
    cpu_state_t   cpu;
    logic         perf_valid;
    logic [3:0]   perf;
    logic         mode_valid;
    logic         mode_visible;
    logic [1:0]   mode;
  } pm_req_t;

  // Policy outputs derived from the current states
  typedef struct packed {
    logic       decode_en;
    logic       context_kept;
    logic       need_reinit;
    logic [1:0] power_level;
    logic       cpu_ctx_kept;
    logic       cache_ctx_kept;
    logic       mem_only_kept;
    logic       restore_cfg;
    logic       wake_at_reset_vec;
    logic       devices_off;
    logic       longest_wake;
    logic       boot_from_image;
    logic       cpu_executing;
    logic       snoop_ignore;
    logic       exit_latency_report;
    logic       perf_applies;
    logic       perf_max;
    logic       perf_min;
  } pm_policy_t;

endpackage

// [testbench/power_state_tracker_asserts.sv]
`timescale 1ns/1ps
module power_state_tracker_asserts
  import power_state_pkg::*;
(
  // Clock and reset
  input wire logic         clk,
  input wire logic         reset_n,
  // Inputs
  input wire pm_req_t      req,
  input wire logic         addr_hit,
  // Outputs
  input wire logic         addr_claim,
  input wire dev_state_t   dev_state,
  input wire sleep_state_t sleep_state,
  input wire cpu_state_t   cpu_state,
  input wire logic [3:0]   perf_state,
  input wire pm_policy_t   policy,
  input wire logic         req_error
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_OFF_NO_CLAIM: assert property (dev_state == dev_off |=> !addr_claim)
    else $error("claim while device off");
  AST_ON_CLAIM: assert property (addr_hit && dev_state != dev_off |=> addr_claim)
    else $error("no claim while device on");
  AST_OFF_POLICY: assert property (dev_state == dev_off |-> policy.need_reinit && !policy.decode_en)
    else $error("off policy wrong");
  AST_LEVEL: assert property (policy.power_level == PWR_LVL_FULL - dev_state)
    else $error("power level wrong");
  AST_HOLD: assert property (!req.dev_valid && !req.cpu_valid |=> $stable(dev_state) && $stable(cpu_state))
    else $error("state changed without request");
  AST_SLEEP_REJ: assert property (req.sleep_valid && req.sleep > sleep_soft_off |=> req_error && $stable(sleep_state))
    else $error("bad sleep code taken");
  AST_SNOOP: assert property (policy.snoop_ignore == (cpu_state == cpu_idle3))
    else $error("snoop flag wrong");
  AST_EXEC: assert property (policy.cpu_executing ==
    (cpu_state == cpu_active && sleep_state == sleep_none))
    else $error("execute flag wrong");
  AST_PERF_APPLIES: assert property (policy.perf_applies ==
    ((cpu_state == cpu_active && sleep_state == sleep_none) || dev_state == dev_full_on))
    else $error("perf applies wrong");
  AST_PERF_MAX: assert property (policy.perf_max == (policy.perf_applies && perf_state == PERF_TOP))
    else $error("perf max wrong");
endmodule

// [testbench/power_state_tracker_tb.sv]
`timescale 1ns/1ps
module power_state_tracker_tb
  import power_state_pkg::*;
;
  logic         clk = 1'b0;
  logic         reset_n = 1'b0;
  pm_req_t      req = '0;
  logic         auto_mode_req = 1'b0;
  logic [1:0]   auto_mode = 2'h0;
  logic         addr_hit = 1'b0;
  logic         addr_claim;
  dev_state_t   dev_state;
  sleep_state_t sleep_state;
  cpu_state_t   cpu_state;
  logic [3:0]   perf_state;
  logic [1:0]   int_mode;
  pm_policy_t   policy;
  logic         req_error;
  int           num_errors = 0;
  int           comparisons = 0;
  pm_req_t      r;
  always #2 clk = ~clk;
  power_state_tracker #(.PERF_STATES(8)) power_state_tracker_i (.clk(clk), .reset_n(reset_n), .req(req),
    .auto_mode_req(auto_mode_req), .auto_mode(auto_mode), .addr_hit(addr_hit), .addr_claim(addr_claim),
    .dev_state(dev_state), .sleep_state(sleep_state), .cpu_state(cpu_state), .perf_state(perf_state),
    .int_mode(int_mode), .policy(policy), .req_error(req_error));
  task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  // One request cycle, outputs settled on return
  task send(input pm_req_t q);
    @(posedge clk) req <= q;
    @(posedge clk) req <= '0;
    #1;
  endtask
  task end_of_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task t_dev;
    for (int d = 3; d >= 0; d--) begin
      r = '0;
      r.dev_valid = 1'b1;
      r.dev = dev_state_t'(d);
      send(r);
      chk("level", 8'(policy.power_level), 8'(3 - d));
      chk("reinit", 8'(policy.need_reinit), 8'(d == 3));
      chk("ctx", 8'(policy.context_kept), 8'(d <= 1));
      @(posedge clk) addr_hit <= 1'b1;
      @(posedge clk) addr_hit <= 1'b0;
      #1 chk("claim", 8'(addr_claim), 8'(d != 3));
    end
  endtask
  task t_sleep;
    int e;
    for (int s = 0; s < 8; s++) begin
      e = (s > 5) ? 5 : s;
      r = '0;
      r.sleep_valid = 1'b1;
      r.sleep = sleep_state_t'(s);
      send(r);
      chk("sleep", 8'(sleep_state), 8'(e));
      chk("sleep_err", 8'(req_error), 8'(s > 5));
      chk("image", 8'(policy.boot_from_image), 8'(e == 4));
      chk("cpu_ctx", 8'(policy.cpu_ctx_kept), 8'(e <= 1));
      chk("cache_ctx", 8'(policy.cache_ctx_kept), 8'(e <= 1));
      chk("reset_vec", 8'(policy.wake_at_reset_vec), 8'(e == 2 || e == 3));
      chk("mem_only", 8'({policy.mem_only_kept, policy.restore_cfg}), 8'(e == 3 ? 3 : 0));
      chk("dev_off", 8'({policy.devices_off, policy.longest_wake}), 8'(e == 4 ? 3 : (e == 5 ? 2 : 0)));
      chk("exec_sleep", 8'(policy.cpu_executing), 8'(e == 0));
    end
    r = '0;
    r.sleep_valid = 1'b1;
    r.sleep = sleep_none;
    send(r);
    chk("wake", 8'(sleep_state), 8'h00);
  endtask
  task t_cpu_perf;
    for (int c = 0; c < 4; c++) begin
      r = '0;
      r.cpu_valid = 1'b1;
      r.cpu = cpu_state_t'(c);
      send(r);
      chk("cpu", 8'(cpu_state), 8'(c));
      chk("snoop", 8'(policy.snoop_ignore), 8'(c == 3));
      chk("exec", 8'(policy.cpu_executing), 8'(c == 0));
      chk("exit_lat", 8'(policy.exit_latency_report), 8'(c >= 2));
    end
    for (int p = 0; p < 10; p++) begin
      r = '0;
      r.perf_valid = 1'b1;
      r.perf = 4'(p);
      send(r);
      chk("perf", 8'(perf_state), 8'(p > 7 ? 7 : p));
      chk("perf_err", 8'(req_error), 8'(p > 7));
      chk("perf_min", 8'(policy.perf_min), 8'(p >= 7));
      chk("perf_max", 8'(policy.perf_max), 8'(p == 0));
    end
  endtask
  task t_mode;
    @(posedge clk) auto_mode_req <= 1'b1;
    auto_mode <= 2'h3;
    @(posedge clk) auto_mode_req <= 1'b0;
    #1 chk("auto", 8'(int_mode), 8'h03);
    r = '0;
    r.mode_valid = 1'b1;
    r.mode_visible = 1'b1;
    r.mode = 2'h2;
    @(posedge clk) req <= r;
    auto_mode_req <= 1'b1;
    @(posedge clk) req <= '0;
    auto_mode_req <= 1'b0;
    #1 chk("cmd", 8'(int_mode), 8'h02);
    r = '0;
    r.dev_valid = 1'b1;
    r.dev = dev_off;
    @(posedge clk) req <= r;
    auto_mode_req <= 1'b1;
    @(posedge clk) req <= '0;
    @(posedge clk) auto_mode_req <= 1'b0;
    #1 chk("off_mode", 8'(int_mode), 8'h00);
    chk("perf_off", 8'({policy.perf_applies, policy.perf_min}), 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    #1 chk("dev_rst", 8'(dev_state), 8'h00);
    chk("on_pol", 8'({policy.decode_en, policy.context_kept, policy.need_reinit}), 8'h06);
    t_dev;
    t_sleep;
    t_cpu_perf;
    t_mode;
    end_of_test;
  end
  initial begin
    #20000;
    num_errors++;
    end_of_test;
  end
endmodule
bind power_state_tracker power_state_tracker_asserts power_state_tracker_asserts_i (.clk(clk), .reset_n(reset_n),
  .req(req), .addr_hit(addr_hit), .addr_claim(addr_claim), .dev_state(dev_state), .sleep_state(sleep_state),
  .cpu_state(cpu_state), .perf_state(perf_state), .policy(policy), .req_error(req_error));
